// ==== design/rcse_pkg.sv ====
// Constants and types of the radio command sequencer execution unit
package rcse_pkg;
  localparam int          MEM_DEPTH     = 24;
  localparam int          PTR_W         = 5;
  localparam logic [7:0]  OPC_IDLE      = 8'hc0;
  localparam logic [7:0]  OPC_HALT      = 8'hdf;
  localparam logic [7:0]  OPC_DEC_Z     = 8'hbf;
  localparam logic [7:0]  OPC_DEC_Y     = 8'hbe;
  localparam logic [7:0]  OPC_INC_Y     = 8'hbd;
  localparam logic [7:0]  OPC_RAND      = 8'hbc;
  localparam logic [7:0]  OPC_DELAY_X   = 8'hbb;
  localparam logic [7:0]  OPC_MARK      = 8'hba;
  localparam logic [7:0]  OPC_SWI       = 8'hb9;
  localparam logic [7:0]  OPC_DELAY_CMP = 8'hb8;
  localparam logic [7:0]  OPC_TX_CAL    = 8'hc1;
  localparam logic [7:0]  OPC_RX_EN     = 8'hc2;
  localparam logic [7:0]  OPC_TX_EN     = 8'hc3;
  localparam logic [7:0]  OPC_TX_CCA    = 8'hc4;
  localparam logic [4:0]  PFX_SAT       = 5'h16;
  localparam logic [3:0]  PFX_LOOP      = 4'ha;
  localparam logic [2:0]  PFX_WAIT      = 3'h4;
  localparam logic [5:0]  WAIT_ZERO_CNT = 6'h20;
  localparam logic [PTR_W-1:0] LAST_ADDR = 5'h17;
  localparam logic [PTR_W-1:0] COND_PC   = 5'h17;
  localparam logic [2:0]  C_CCA  = 3'h0;
  localparam logic [2:0]  C_SFD  = 3'h1;
  localparam logic [2:0]  C_HOST = 3'h2;
  localparam logic [2:0]  C_END  = 3'h3;
  localparam logic [2:0]  C_X    = 3'h4;
  localparam logic [2:0]  C_Y    = 3'h5;
  localparam logic [2:0]  C_Z    = 3'h6;

  typedef enum logic [1:0] {RCSE_IDLE, RCSE_EXEC, RCSE_WAIT, RCSE_ACK} rcse_state_t;

  typedef struct packed {
    logic tx_cal;
    logic rx_en;
    logic tx_en;
    logic tx_cca;
  } rcse_strobe_t;

  typedef struct packed {
    logic cca;
    logic sfd;
  } rcse_radio_t;
endpackage

// ==== design/rcse_sequencer_core.sv ====
// Execution and decode logic of the radio command sequencer
`timescale 1ns/100ps
module rcse_sequencer_core
  import rcse_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Host command port
  input  wire logic         cmd_wr,
  input  wire logic [7:0]   cmd_data,
  input  wire logic         start_cmd,
  input  wire logic         host_condition_bit,
  // Scratch register load from host
  input  wire logic         scratch_wr,
  input  wire logic [23:0]  scratch_wdata,
  // Timer and random source
  input  wire logic         timer_overflow,
  input  wire logic         timer_compare,
  input  wire logic [7:0]   random_source_out,
  // Radio
  input  rcse_radio_t       radio_cond,
  input  wire logic         radio_ack,
  output rcse_strobe_t      radio_strobe_r,
  output logic              rx_enable_strobe_out,
  // Status
  output logic              running_r,
  output logic [7:0]        scratch_x,
  output logic [7:0]        scratch_y,
  output logic [7:0]        scratch_z,
  output logic              prog_irq_flag,
  output logic              wait_done_flag,
  output logic              halt_flag
);

  logic [7:0]       mem_r [MEM_DEPTH];
  logic [PTR_W-1:0] pc_r;
  logic [PTR_W-1:0] wptr_r;
  logic [PTR_W-1:0] mark_r;
  logic             mark_valid_r;
  rcse_state_t      state_r;
  logic [5:0]       wcnt_r;
  logic [7:0]       op_r;
  logic [7:0]       x_r;
  logic [7:0]       y_r;
  logic [7:0]       z_r;
  logic             int_r;
  logic             wt_r;
  logic             stp_r;

  // Condition select with optional negation
  function automatic logic cond_true(input logic [3:0] nc, input logic [PTR_W-1:0] pc,
                                     input logic [7:0] x, input logic [7:0] y,
                                     input logic [7:0] z, input rcse_radio_t r,
                                     input logic hb);
    logic c;
    c = 1'b0;
    if (nc[2:0] == C_CCA) c = r.cca;
    else if (nc[2:0] == C_SFD) c = r.sfd;
    else if (nc[2:0] == C_HOST) c = hb;
    else if (nc[2:0] == C_END) c = (pc == COND_PC);
    else if (nc[2:0] == C_X) c = (x == 8'h00);
    else if (nc[2:0] == C_Y) c = (y == 8'h00);
    else if (nc[2:0] == C_Z) c = (z == 8'h00);
    return c ^ nc[3];
  endfunction

  logic [7:0] op;
  logic       cnd;
  logic       at_end;
  logic       is_halt;
  logic       is_strobe;
  logic       wait_over;
  assign op        = mem_r[pc_r];
  // Any wait ends this cycle, whichever kind is pending
  assign wait_over = (op_r == OPC_DELAY_CMP) ? timer_compare :
                     (op_r == OPC_DELAY_X) ? (x_r == 8'h00 || (timer_overflow && x_r == 8'h01)) :
                     (timer_overflow && wcnt_r == 6'h01);
  assign cnd       = cond_true(op[3:0], pc_r, x_r, y_r, z_r, radio_cond, host_condition_bit);
  assign at_end    = (pc_r == LAST_ADDR);
  assign is_halt   = (state_r == RCSE_EXEC) && (op == OPC_HALT);
  assign is_strobe = (op == OPC_TX_CAL) || (op == OPC_RX_EN) ||
                     (op == OPC_TX_EN) || (op == OPC_TX_CCA);

  // Control state, program counter and waits
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= RCSE_IDLE;
      pc_r    <= '0;
      wcnt_r  <= '0;
      op_r    <= OPC_IDLE;
    end else begin
      case (state_r)
        RCSE_IDLE: begin
          if (start_cmd) begin
            pc_r    <= '0;
            state_r <= RCSE_EXEC;
          end
        end
        RCSE_EXEC: begin
          op_r <= op;
          if (op == OPC_HALT) begin
            pc_r    <= '0;
            state_r <= RCSE_IDLE;
          end else if (op == OPC_DELAY_X) begin
            state_r <= RCSE_WAIT;
          end else if (op[7:5] == PFX_WAIT) begin
            wcnt_r  <= (op[4:0] == 5'h00) ? WAIT_ZERO_CNT : {1'b0, op[4:0]};
            state_r <= RCSE_WAIT;
          end else if (op == OPC_DELAY_CMP) begin
            state_r <= RCSE_WAIT;
          end else if (is_strobe) begin
            state_r <= RCSE_ACK;
          end else if (op[7:4] == PFX_LOOP) begin
            if (cnd && mark_valid_r) pc_r <= mark_r;
            else if (at_end) state_r <= RCSE_IDLE;
            else pc_r <= pc_r + 5'h01;
          end else if (op[7] == 1'b0) begin
            // Skip past the end stops execution
            if ({1'b0, pc_r} + {3'h0, op[6:4]} + 6'h01 > {1'b0, LAST_ADDR} && cnd)
              state_r <= RCSE_IDLE;
            else if (cnd) pc_r <= pc_r + {2'h0, op[6:4]} + 5'h01;
            else if (at_end) state_r <= RCSE_IDLE;
            else pc_r <= pc_r + 5'h01;
          end else begin
            // Single-cycle instructions, no-op and unassigned codes
            if (at_end) state_r <= RCSE_IDLE;
            else pc_r <= pc_r + 5'h01;
          end
        end
        RCSE_WAIT: begin
          if (op_r == OPC_DELAY_CMP) begin
            if (timer_compare) begin
              if (at_end) state_r <= RCSE_IDLE;
              else begin
                pc_r    <= pc_r + 5'h01;
                state_r <= RCSE_EXEC;
              end
            end
          end else if (op_r == OPC_DELAY_X) begin
            if (x_r == 8'h00 || (timer_overflow && x_r == 8'h01)) begin
              if (at_end) state_r <= RCSE_IDLE;
              else begin
                pc_r    <= pc_r + 5'h01;
                state_r <= RCSE_EXEC;
              end
            end
          end else if (timer_overflow) begin
            wcnt_r <= wcnt_r - 6'h01;
            if (wcnt_r == 6'h01) begin
              if (at_end) state_r <= RCSE_IDLE;
              else begin
                pc_r    <= pc_r + 5'h01;
                state_r <= RCSE_EXEC;
              end
            end
          end
        end
        RCSE_ACK: begin
          if (radio_ack) begin
            if (at_end) state_r <= RCSE_IDLE;
            else begin
              pc_r    <= pc_r + 5'h01;
              state_r <= RCSE_EXEC;
            end
          end
        end
        default: state_r <= RCSE_IDLE;
      endcase
    end
  end

  // Instruction memory and write pointer
  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_r <= '0;
      for (int i = 0; i < MEM_DEPTH; i++) mem_r[i] <= OPC_IDLE;
    end else if (is_halt) begin
      wptr_r <= '0;
      for (int i = 0; i < MEM_DEPTH; i++) mem_r[i] <= OPC_IDLE;
    end else if (cmd_wr && state_r == RCSE_IDLE && wptr_r <= LAST_ADDR) begin
      mem_r[wptr_r] <= cmd_data;
      wptr_r        <= wptr_r + 5'h01;
    end
  end

  // Loop start register
  always_ff @(posedge clk) begin
    if (rst) begin
      mark_r       <= '0;
      mark_valid_r <= 1'b0;
    end else if (is_halt) begin
      mark_valid_r <= 1'b0;
    end else if (state_r == RCSE_EXEC && op == OPC_MARK) begin
      mark_r       <= at_end ? pc_r : pc_r + 5'h01;
      mark_valid_r <= 1'b1;
    end
  end

  // Scratch registers
  always_ff @(posedge clk) begin
    if (rst) begin
      x_r <= '0;
      y_r <= '0;
      z_r <= '0;
    end else if (scratch_wr && state_r == RCSE_IDLE) begin
      x_r <= scratch_wdata[7:0];
      y_r <= scratch_wdata[15:8];
      z_r <= scratch_wdata[23:16];
    end else if (state_r == RCSE_EXEC) begin
      if (op == OPC_DEC_Y) y_r <= y_r - 8'h01;
      else if (op == OPC_INC_Y) y_r <= y_r + 8'h01;
      else if (op == OPC_DEC_Z) z_r <= z_r - 8'h01;
      else if (op[7:3] == PFX_SAT)
        y_r <= ({1'b0, y_r} + 9'h001 < {6'h00, op[2:0]}) ? y_r + 8'h01 : {5'h00, op[2:0]};
      else if (op == OPC_RAND) begin
        for (int b = 0; b < 8; b++)
          x_r[b] <= (b < y_r) ? random_source_out[b] : 1'b0;
      end
    end else if (state_r == RCSE_WAIT && op_r == OPC_DELAY_X && timer_overflow
                 && x_r != 8'h00) begin
      x_r <= x_r - 8'h01;
    end
  end

  // Event flags, one-cycle pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      int_r <= 1'b0;
      wt_r  <= 1'b0;
      stp_r <= 1'b0;
    end else begin
      int_r <= (state_r == RCSE_EXEC) && (op == OPC_SWI);
      wt_r  <= (state_r == RCSE_WAIT) && (op_r != OPC_DELAY_CMP) &&
               ((op_r == OPC_DELAY_X) ? (x_r == 8'h00 || (timer_overflow && x_r == 8'h01))
                                      : (timer_overflow && wcnt_r == 6'h01));
      stp_r <= is_halt ||
               (state_r != RCSE_IDLE && at_end &&
                ((state_r == RCSE_ACK && radio_ack) ||
                 (state_r == RCSE_WAIT && wait_over) ||
                 (state_r == RCSE_EXEC && !is_strobe && op != OPC_DELAY_X &&
                  op != OPC_DELAY_CMP && op[7:5] != PFX_WAIT &&
                  !(op[7:4] == PFX_LOOP && cnd && mark_valid_r))));
    end
  end

  // Radio strobes, one pulse on issue; radio judges the channel for tx_cca
  always_ff @(posedge clk) begin
    if (rst) begin
      radio_strobe_r       <= '0;
      rx_enable_strobe_out <= 1'b0;
    end else begin
      radio_strobe_r.tx_cal <= (state_r == RCSE_EXEC) && (op == OPC_TX_CAL);
      radio_strobe_r.rx_en  <= (state_r == RCSE_EXEC) && (op == OPC_RX_EN);
      radio_strobe_r.tx_en  <= (state_r == RCSE_EXEC) && (op == OPC_TX_EN);
      radio_strobe_r.tx_cca <= (state_r == RCSE_EXEC) && (op == OPC_TX_CCA);
      rx_enable_strobe_out  <= (state_r == RCSE_EXEC) && (op == OPC_RX_EN);
    end
  end

  // Registered status outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      running_r <= 1'b0;
      scratch_x <= '0;
      scratch_y <= '0;
      scratch_z <= '0;
    end else begin
      running_r <= (state_r != RCSE_IDLE);
      scratch_x <= x_r;
      scratch_y <= y_r;
      scratch_z <= z_r;
    end
  end

  assign prog_irq_flag  = int_r;
  assign wait_done_flag = wt_r;
  assign halt_flag      = stp_r;

endmodule // rcse_sequencer_core

// ==== tb/rcse_props.sv ====
// Checker of strobe, halt, start and idle behaviour at the core's ports
`timescale 1ns/100ps
module rcse_props
  import rcse_pkg::*;
(
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst,
  // Host side
  input wire logic         start_cmd,
  input wire logic         scratch_wr,
  // Radio
  input wire logic         radio_ack,
  input rcse_strobe_t      radio_strobe_r,
  input wire logic         rx_enable_strobe_out,
  // Status
  input wire logic         running_r,
  input wire logic [7:0]   scratch_x,
  input wire logic [7:0]   scratch_y,
  input wire logic [7:0]   scratch_z,
  input wire logic         halt_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Strobe out with no acknowledge at that sample, and none at the next sample
  sequence s_unacked;
    (|radio_strobe_r) && !radio_ack ##1 !radio_ack;
  endsequence
  AST_ONE_STROBE: assert property ($onehot0(radio_strobe_r))
    else $error("two strobes at once");
  AST_RX_MIRROR: assert property (rx_enable_strobe_out == radio_strobe_r.rx_en)
    else $error("rx strobe output mismatch");
  AST_PULSE: assert property (|radio_strobe_r |=> radio_strobe_r == '0)
    else $error("strobe longer than one cycle");
  AST_STROBE_RUN: assert property (|radio_strobe_r |-> running_r)
    else $error("strobe while idle");
  AST_STALL: assert property (s_unacked |=> radio_strobe_r == '0)
    else $error("strobe before acknowledge");
  AST_HALT_STOP: assert property (halt_flag |=> !running_r && !halt_flag)
    else $error("running after halt");
  AST_START: assert property (start_cmd |-> ##[1:3] running_r)
    else $error("start did not run");
  AST_IDLE_HOLD: assert property (!running_r && !$past(running_r) &&
    !$past(running_r, 2) && !$past(scratch_wr) && !$past(scratch_wr, 2)
    |-> $stable({scratch_x, scratch_y, scratch_z}))
    else $error("scratch changed while idle");
endmodule // rcse_props
bind rcse_sequencer_core rcse_props i_props (.clk(clk), .rst(rst), .start_cmd(start_cmd),
  .scratch_wr(scratch_wr), .radio_ack(radio_ack), .radio_strobe_r(radio_strobe_r),
  .rx_enable_strobe_out(rx_enable_strobe_out), .running_r(running_r),
  .scratch_x(scratch_x), .scratch_y(scratch_y), .scratch_z(scratch_z), .halt_flag(halt_flag));

// ==== tb/rcse_far_model.sv ====
// Far side: radio acknowledge and free-running MAC timer
`timescale 1ns/100ps
module rcse_far_model
  import rcse_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Radio
  input rcse_strobe_t     strobe,
  input wire logic [3:0]  ack_dly,
  output logic            radio_ack,
  // Timer
  output logic            timer_overflow,
  output logic            timer_compare
);
  logic [3:0] ack_cnt_r;
  logic [2:0] tmr_r;
  // Every command, transmit-if-clear too, is answered ack_dly+1 cycles after its strobe; with ack_dly of 0 none is answered
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_cnt_r <= 4'h0;
      radio_ack <= 1'b0;
    end else begin
      radio_ack <= (ack_cnt_r == 4'h1);
      if (|strobe) ack_cnt_r <= ack_dly;
      else if (ack_cnt_r != 4'h0) ack_cnt_r <= ack_cnt_r - 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) tmr_r <= 3'h0;
    else tmr_r <= tmr_r + 3'h1;
  end
  // Single-cycle timer pulses
  assign timer_overflow = (tmr_r == 3'h7);
  assign timer_compare  = (tmr_r == 3'h3);
endmodule // rcse_far_model

// ==== tb/tb_top.sv ====
// Self-checking bench of the sequencer execution core
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top
  import rcse_pkg::*;
;
  logic         clk = 1'b0, rst = 1'b1, cmd_wr = 1'b0, start_cmd = 1'b0, scratch_wr = 1'b0;
  logic [7:0]   cmd_data = 8'h00;
  logic [23:0]  scratch_wdata = 24'h000000;
  logic [3:0]   ack_dly = 4'h1;
  logic [6:0]   cond_m = 7'h55;
  logic         timer_overflow, timer_compare, radio_ack, rx_enable_strobe_out, running_r;
  logic         prog_irq_flag, wait_done_flag, halt_flag;
  logic [7:0]   scratch_x, scratch_y, scratch_z;
  logic [3:0]   seen;
  rcse_strobe_t radio_strobe_r;
  int n_fail = 0, total_checks = 0, cyc = 0, n_p, n_w, n_h, n_rx, n_ov, n, c, d;
  always #2.5 clk = ~clk;
  rcse_sequencer_core i_dut (.clk, .rst, .cmd_wr, .cmd_data, .start_cmd,
    .host_condition_bit(1'b1), .scratch_wr, .scratch_wdata, .timer_overflow, .timer_compare,
    .random_source_out(8'hff), .radio_cond(2'h2), .radio_ack, .radio_strobe_r,
    .rx_enable_strobe_out, .running_r, .scratch_x, .scratch_y, .scratch_z,
    .prog_irq_flag, .wait_done_flag, .halt_flag);
  rcse_far_model i_far (.clk, .rst, .strobe(radio_strobe_r), .ack_dly, .radio_ack,
    .timer_overflow, .timer_compare);
  task automatic summarize();
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
    n_p += prog_irq_flag;
    n_w += wait_done_flag;
    n_h += halt_flag;
    n_rx += rx_enable_strobe_out;
    n_ov += (running_r && timer_overflow);
    seen |= radio_strobe_r;
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // Preload {z,y,x}, run up to five opcodes then halt, compare scratch and counts
  task automatic run(input [23:0] pre, input [39:0] ops, input [23:0] ex,
                     input int w, input [3:0] sm, input int np, input int nw);
    int i;
    scratch_wr = 1'b1;
    scratch_wdata = pre;
    tick();
    scratch_wr = 1'b0;
    for (i = 4; i >= 0 && ops != 40'h0; i--) begin
      cmd_wr = 1'b1;
      cmd_data = ops[8*i +: 8];
      tick();
    end
    cmd_data = OPC_HALT;
    if (ops != 40'h0) tick();
    cmd_wr = 1'b0;
    {n_p, n_w, n_h, n_rx, n_ov} = '0;
    seen = 4'h0;
    start_cmd = 1'b1;
    tick();
    start_cmd = 1'b0;
    for (i = 0; i < 10 && running_r !== 1'b1; i++) tick();
    for (i = 0; i < 400 && running_r !== 1'b0; i++) tick();
    repeat (3) tick();
    `CHK("scratch", ex, {scratch_z, scratch_y, scratch_x})
    `CHK("halt_count", 1, n_h)
    `CHK("prog_count", np, n_p)
    `CHK("wait_count", nw, n_w)
    `CHK("strobes", sm, seen)
    `CHK("rx_count", int'(sm[2]), n_rx)
    if (w != 0) `CHK("overflows", 1'b1, n_ov >= w && n_ov <= w + 1)
  endtask
  initial begin
    repeat (8) tick();
    rst = 1'b0;
    `CHK("reset_scratch", 24'h000000, {scratch_z, scratch_y, scratch_x})
    run(24'h000000, 40'h0, 24'h000000, 0, 4'h0, 0, 0);
    run(24'h00ff00, 40'hbdc0c0c0c0, 24'h000000, 0, 4'h0, 0, 0);
    run(24'h000000, 40'hbec0c0c0c0, 24'h00ff00, 0, 4'h0, 0, 0);
    run(24'h000200, 40'hb3c0c0c0c0, 24'h000300, 0, 4'h0, 0, 0);
    run(24'h000500, 40'hb3c0c0c0c0, 24'h000300, 0, 4'h0, 0, 0);
    run(24'h0003aa, 40'hbcc0c0c0c0, 24'h000307, 0, 4'h0, 0, 0);
    run(24'h000300, 40'hbabfbeadc0, 24'hfd0000, 0, 4'h0, 0, 0);
    run(24'h00fe00, 40'hbabfbabdad, 24'hff0000, 0, 4'h0, 0, 0);
    run(24'h00ff00, 40'hbda5bdc0c0, 24'h000100, 0, 4'h0, 0, 0);
    run(24'h000000, 40'hb9d5c0c0c0, 24'h000000, 0, 4'h0, 1, 0);
    run(24'h000000, 40'h83c0c0c0c0, 24'h000000, 3, 4'h0, 0, 1);
    run(24'h000000, 40'h80c0c0c0c0, 24'h000000, 32, 4'h0, 0, 1);
    run(24'h000002, 40'hbbc0c0c0c0, 24'h000000, 2, 4'h0, 0, 1);
    run(24'h000000, 40'hb8c0c0c0c0, 24'h000000, 0, 4'h0, 0, 0);
    for (d = 1; d < 10; d += 8) begin
      ack_dly = d[3:0];
      run(24'h000000, 40'hc1c2c3c4c0, 24'h000000, 0, 4'hf, 0, 0);
    end
    for (n = 0; n < 2; n++)
      for (c = 0; c < 7; c++)
        run(24'h000500, {1'b0, 3'h1, n[0], c[2:0], 32'hbdc0c0c0},
            (cond_m[c] ^ n[0]) ? 24'h000500 : 24'h000600, 0, 4'h0, 0, 0);
    summarize();
  end
endmodule // tb_top
